//--- include/iis_pkg.sv
// constants and types shared by the instruction issue scoreboard
package iis_pkg;
  localparam int HALF_W = 24;
  localparam int WORD_W = 48;
  localparam int N_UNITS = 3;
  localparam int UNIT_INT = 0;
  localparam int UNIT_FP = 1;
  localparam int UNIT_MEM = 2;
  localparam int TIME_W = 6;
  localparam int PC_W = 16;
  localparam int STAGE_DEPTH = 2;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MEM_CYCLE_CLK = 3;
  localparam int JUMP_PENALTY_CLK = 3;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [1:0] STAGE_CNT_RESET = 2'h0;
  localparam logic [1:0] MEM_AGE_RESET = 2'h0;

  typedef logic [TIME_W-1:0] iis_time_t;

  typedef enum logic [1:0] {
    FS_RUN,
    FS_PENALTY,
    FS_HALT
  } iis_fetch_e;
endpackage

//--- rtl/iis_issue_scoreboard.sv
// instruction staging, holding register, scoreboard and fetch control
//
// Overview of operation
// [RQ1] Track three units, integer, floating point and memory, each used or unused per instruction.
// [RQ2] Issue only after the staged instruction has been decoded for at least one clock.
// [RQ3] Occupancy n-m: previous may hold unit until clock n; current holds until m.
// [RQ4] Wait, stop and help halt fetching until the control unit restarts it.
// [RQ5] Decode start times and holding time from the staged first half each clock.
// [RQ6] Each unit presents the ending time of its current instruction.
// [RQ7] Issue only when all three unit comparisons show no conflict.
// [RQ8] Instructions with delayed starts move into the holding register, freeing staging.
// [RQ9] Program counter addresses the word after the staging contents.
// [RQ10] Store word valid only three clocks after its address; staging waits.
// [RQ11] Half-word instructions share words; full-word ones may straddle two words.
// [RQ12] Timing from first half; full-word issue waits for its second half.
// [RQ13] Address, branch or literal instructions are 48 bits; others 24 bits.
// [RQ14] Taken jump blocks issue for three extra clocks.
// [RQ15] All timing counts in clocks of the single processor clock.
// [RQ16] Reset empties staging and holding and leaves every unit idle.
`timescale 1ns/10ps
`default_nettype none
module iis_issue_scoreboard
  import iis_pkg::*;
#(
  parameter int P_PC_W = iis_pkg::PC_W,
  parameter int P_TIME_W = iis_pkg::TIME_W
) (
  // clock and control
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // instruction store
  output logic [P_PC_W-1:0] store_addr,
  input wire logic [iis_pkg::WORD_W-1:0] store_data,
  // staged first half and its decode
  output logic [iis_pkg::HALF_W-1:0] stage_half,
  output logic stage_valid,
  input wire logic dec_full,
  input wire logic [iis_pkg::N_UNITS-1:0] dec_use,
  input wire logic [iis_pkg::N_UNITS-1:0][P_TIME_W-1:0] dec_start,
  input wire logic [iis_pkg::N_UNITS-1:0][P_TIME_W-1:0] dec_end,
  input wire logic [P_TIME_W-1:0] dec_hold_time,
  input wire logic dec_halt,
  // program flow from execution logic
  input wire logic jump_taken,
  input wire logic [P_PC_W-1:0] jump_target,
  input wire logic restart,
  // issue to execution logic
  output logic issue_valid,
  output logic [iis_pkg::N_UNITS-1:0] issue_unit,
  output logic [iis_pkg::WORD_W-1:0] issue_word,
  output logic hold_valid,
  output logic [iis_pkg::WORD_W-1:0] hold_word,
  output logic [iis_pkg::N_UNITS-1:0][P_TIME_W-1:0] unit_busy,
  output logic fetch_halted
);
  import iis_pkg::*;

  // the reset address is only as wide as the package constant
  if (P_PC_W < 2 || P_PC_W > PC_W || P_TIME_W < 3) begin : g_param_check
    $error("iis_issue_scoreboard: parameter out of range");
  end

  logic [P_PC_W-1:0] pc_ff, nxt_pc;
  logic [HALF_W-1:0] stage_lo_ff, nxt_stage_lo;
  logic [HALF_W-1:0] stage_hi_ff, nxt_stage_hi;
  logic [1:0] stage_cnt_ff, nxt_stage_cnt;
  logic stage_valid_ff, nxt_stage_valid;
  logic dec_ok_ff, nxt_dec_ok;
  logic half_sel_ff, nxt_half_sel;
  logic [1:0] mem_age_ff, nxt_mem_age;
  logic [1:0] pen_cnt_ff, nxt_pen_cnt;
  iis_fetch_e state_ff, nxt_state;
  logic halted_ff, nxt_halted;
  logic [P_TIME_W-1:0] hold_cnt_ff, nxt_hold_cnt;
  logic hold_valid_ff, nxt_hold_valid;
  logic [WORD_W-1:0] hold_word_ff, nxt_hold_word;
  logic [WORD_W-1:0] issue_word_ff, nxt_issue_word;
  logic issue_valid_ff;
  logic [N_UNITS-1:0] issue_unit_ff;
  logic [N_UNITS-1:0][P_TIME_W-1:0] busy_ff;
  logic [N_UNITS-1:0] unit_ok;
  logic can_issue, full_ok, mem_valid, fill;
  logic [1:0] take, cnt_after;
  logic [HALF_W-1:0] fill_half;

  // per-unit occupancy counter and start-time comparison
  genvar gu;
  generate
    for (gu = 0; gu < N_UNITS; gu++) begin : g_unit
      logic [P_TIME_W-1:0] nxt_busy;
      logic nxt_issue_u;
      always_comb begin
        unit_ok[gu] = !dec_use[gu] || (busy_ff[gu] <= dec_start[gu]); // RQ3
        nxt_issue_u = can_issue && dec_use[gu]; // RQ1
        if (nxt_issue_u) begin
          nxt_busy = dec_end[gu]; // RQ6
        end else if (busy_ff[gu] != '0) begin
          nxt_busy = busy_ff[gu] - 1'b1; // RQ15
        end else begin
          nxt_busy = '0;
        end
      end
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          busy_ff[gu] <= '0; // RQ16
          issue_unit_ff[gu] <= 1'b0;
        end else if (ce) begin
          busy_ff[gu] <= nxt_busy;
          issue_unit_ff[gu] <= nxt_issue_u;
        end
      end
    end
  endgenerate

  // issue decision, staging refill and fetch control
  always_comb begin
    full_ok = !dec_full || (stage_cnt_ff == 2'd2); // RQ12
    can_issue = (state_ff == FS_RUN) && dec_ok_ff && (&unit_ok) // RQ7
                && (hold_cnt_ff == '0) && full_ok && !jump_taken; // RQ2
    take = !can_issue ? 2'd0 : (dec_full ? 2'd2 : 2'd1); // RQ13
    cnt_after = stage_cnt_ff - take;
    mem_valid = (mem_age_ff == 2'(MEM_CYCLE_CLK)); // RQ10
    fill = mem_valid && (cnt_after < 2'(STAGE_DEPTH)) && (state_ff != FS_HALT) && !jump_taken;
    fill_half = half_sel_ff ? store_data[HALF_W-1:0] : store_data[WORD_W-1:HALF_W]; // RQ11
    nxt_issue_word = {stage_lo_ff, dec_full ? stage_hi_ff : {HALF_W{1'b0}}};
    nxt_stage_lo = (take == 2'd1) ? stage_hi_ff : stage_lo_ff;
    nxt_stage_hi = stage_hi_ff;
    nxt_stage_cnt = cnt_after;
    nxt_pc = pc_ff;
    nxt_half_sel = half_sel_ff;
    nxt_mem_age = mem_valid ? mem_age_ff : mem_age_ff + 1'b1;
    if (fill) begin
      if (cnt_after == 2'd0) begin
        nxt_stage_lo = fill_half;
      end else begin
        nxt_stage_hi = fill_half;
      end
      nxt_stage_cnt = cnt_after + 1'b1;
      nxt_half_sel = !half_sel_ff;
      if (half_sel_ff) begin
        nxt_pc = pc_ff + 1'b1; // RQ9
        nxt_mem_age = MEM_AGE_RESET;
      end
    end
    // a new first half must sit one clock before it may issue
    nxt_dec_ok = (take == 2'd0) && (stage_cnt_ff != 2'd0) && !jump_taken; // RQ5
    nxt_state = state_ff;
    nxt_pen_cnt = pen_cnt_ff;
    case (state_ff)
      FS_RUN: begin
        if (can_issue && dec_halt) begin
          nxt_state = FS_HALT; // RQ4
        end
      end
      FS_PENALTY: begin
        if (pen_cnt_ff == 2'd1) begin
          nxt_state = FS_RUN;
        end
        nxt_pen_cnt = pen_cnt_ff - 1'b1;
      end
      FS_HALT: begin
        if (restart) begin
          nxt_state = FS_RUN;
        end
      end
      default: begin
        nxt_state = FS_RUN;
      end
    endcase
    if (jump_taken) begin
      // everything fetched past the jump is stale
      nxt_pc = jump_target;
      nxt_stage_cnt = STAGE_CNT_RESET;
      nxt_half_sel = 1'b0;
      nxt_mem_age = MEM_AGE_RESET;
      nxt_state = FS_PENALTY;
      nxt_pen_cnt = 2'(JUMP_PENALTY_CLK); // RQ14
    end
    nxt_halted = (nxt_state == FS_HALT); // RQ4
    nxt_stage_valid = (nxt_stage_cnt != 2'd0);
    nxt_hold_word = hold_word_ff;
    if (can_issue && (dec_hold_time != '0)) begin
      nxt_hold_cnt = dec_hold_time; // RQ8
      nxt_hold_word = nxt_issue_word;
    end else if (hold_cnt_ff != '0) begin
      nxt_hold_cnt = hold_cnt_ff - 1'b1;
    end else begin
      nxt_hold_cnt = '0;
    end
    nxt_hold_valid = (nxt_hold_cnt != '0);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pc_ff <= PC_RESET[P_PC_W-1:0];
      stage_lo_ff <= '0;
      stage_hi_ff <= '0;
      stage_cnt_ff <= STAGE_CNT_RESET; // RQ16
      stage_valid_ff <= 1'b0;
      dec_ok_ff <= 1'b0;
      half_sel_ff <= 1'b0;
      mem_age_ff <= MEM_AGE_RESET;
      pen_cnt_ff <= '0;
      state_ff <= FS_RUN;
      halted_ff <= 1'b0;
      hold_cnt_ff <= '0;
      hold_valid_ff <= 1'b0;
      hold_word_ff <= '0;
      issue_word_ff <= '0;
      issue_valid_ff <= 1'b0;
    end else if (ce) begin
      pc_ff <= nxt_pc;
      stage_lo_ff <= nxt_stage_lo;
      stage_hi_ff <= nxt_stage_hi;
      stage_cnt_ff <= nxt_stage_cnt;
      stage_valid_ff <= nxt_stage_valid;
      dec_ok_ff <= nxt_dec_ok;
      half_sel_ff <= nxt_half_sel;
      mem_age_ff <= nxt_mem_age;
      pen_cnt_ff <= nxt_pen_cnt;
      state_ff <= nxt_state;
      halted_ff <= nxt_halted;
      hold_cnt_ff <= nxt_hold_cnt;
      hold_valid_ff <= nxt_hold_valid;
      hold_word_ff <= nxt_hold_word;
      issue_word_ff <= can_issue ? nxt_issue_word : issue_word_ff;
      issue_valid_ff <= can_issue;
    end
  end

  assign store_addr = pc_ff;
  assign stage_half = stage_lo_ff;
  assign stage_valid = stage_valid_ff;
  assign issue_valid = issue_valid_ff;
  assign issue_unit = issue_unit_ff;
  assign issue_word = issue_word_ff;
  assign hold_valid = hold_valid_ff;
  assign hold_word = hold_word_ff;
  assign unit_busy = busy_ff;
  assign fetch_halted = halted_ff;

  a_busy_load_end: assert property (@(posedge sys_clk) disable iff (rst || !ce) // RQ6
    can_issue && dec_use[UNIT_FP] |=> busy_ff[UNIT_FP] == $past(dec_end[UNIT_FP]))
    else $error("fp unit busy count not loaded with end time");
  a_conflict_blocks: assert property (@(posedge sys_clk) disable iff (rst || !ce) // RQ7
    dec_use[UNIT_INT] && (busy_ff[UNIT_INT] > dec_start[UNIT_INT]) |-> !can_issue)
    else $error("issued despite integer unit conflict");
  a_full_waits_half: assert property (@(posedge sys_clk) disable iff (rst || !ce) // RQ12
    can_issue && dec_full |-> stage_cnt_ff == 2'd2)
    else $error("full-word issued without second half");
  a_decode_one_clock: assert property (@(posedge sys_clk) disable iff (rst || !ce) // RQ2
    can_issue |-> $past(stage_valid_ff) && !$past(can_issue))
    else $error("issued without a clock of decode");
  a_store_cycle_wait: assert property (@(posedge sys_clk) disable iff (rst || !ce) // RQ10
    mem_age_ff == 2'd0 |-> (!fill)[*3])
    else $error("staging filled before store word valid");
  a_jump_penalty_hold: assert property (@(posedge sys_clk) disable iff (rst || !ce) // RQ14
    jump_taken |=> (!can_issue)[*3])
    else $error("issue within jump penalty");
  a_halt_no_issue: assert property (@(posedge sys_clk) disable iff (rst || !ce) // RQ4
    can_issue && dec_halt ##1 !restart |-> fetch_halted && !can_issue && !fill)
    else $error("fetch continued after halt");
  a_hold_capture: assert property (@(posedge sys_clk) disable iff (rst || !ce) // RQ8
    can_issue && (dec_hold_time != '0) |=> hold_valid_ff && hold_word_ff == $past(nxt_issue_word))
    else $error("delayed-start instruction not held");
  a_pc_next_word: assert property (@(posedge sys_clk) disable iff (rst || !ce) // RQ9
    fill && half_sel_ff |=> pc_ff == $past(pc_ff) + 1'b1)
    else $error("address did not advance after word used");
  a_reset_idle: assert property (@(posedge sys_clk) disable iff (rst) // RQ16
    $past(rst) |-> busy_ff == '0 && !stage_valid_ff && !hold_valid_ff)
    else $error("not idle after reset");
endmodule
`default_nettype wire

//--- tb/iis_far_side.sv
// instruction store and external decoder facing the issue scoreboard
`timescale 1ns/10ps
`default_nettype none
module iis_far_side (
  // clock
  input wire logic sys_clk,
  // instruction store
  input wire logic [iis_pkg::PC_W-1:0] store_addr,
  output logic [iis_pkg::WORD_W-1:0] store_data,
  // decoder
  input wire logic [iis_pkg::HALF_W-1:0] stage_half,
  output logic dec_full,
  output logic [iis_pkg::N_UNITS-1:0] dec_use,
  output logic [iis_pkg::N_UNITS-1:0][iis_pkg::TIME_W-1:0] dec_start,
  output logic [iis_pkg::N_UNITS-1:0][iis_pkg::TIME_W-1:0] dec_end,
  output logic [iis_pkg::TIME_W-1:0] dec_hold_time,
  output logic dec_halt
);
  import iis_pkg::*;
  logic [WORD_W-1:0] mem [0:15];
  logic [PC_W-1:0] addr_ff = '0;
  logic [1:0] age_ff = 2'h0;
  logic tog_ff = 1'b0;
  always_ff @(posedge sys_clk) begin
    addr_ff <= store_addr;
    tog_ff <= ~tog_ff;
    // case inequality so the unknown address before reset cannot wedge the age
    age_ff <= (store_addr !== addr_ff) ? 2'h1 : ((age_ff == 2'h3) ? age_ff : age_ff + 2'h1);
  end
  // unsettled word toggles so a stale value is never mistaken for data
  assign store_data = (age_ff >= 2'h2 && addr_ff === store_addr) ? mem[store_addr[3:0]] :
                      {24{tog_ff, ~tog_ff}};
  // half layout: 23 full, 22:20 units, 19 halt, 17:12 start, 11:6 hold, 5:0 end
  always_comb begin
    dec_full = stage_half[23];
    dec_use = stage_half[22:20];
    dec_halt = stage_half[19];
    dec_hold_time = stage_half[11:6];
    for (int u = 0; u < N_UNITS; u++) begin
      dec_start[u] = dec_use[u] ? stage_half[17:12] : '0;
      dec_end[u] = dec_use[u] ? stage_half[5:0] : '0;
    end
  end
endmodule
`default_nettype wire

//--- tb/instruction_issue_scoreboard_tb_top.sv
// self-checking bench for the issue scoreboard
`timescale 1ns/10ps
`default_nettype none
module instruction_issue_scoreboard_tb_top;
  import iis_pkg::*;
  localparam logic [23:0] H_A = 24'h100004;
  localparam logic [23:0] H_B = 24'h102004;
  localparam logic [23:0] H_C1 = 24'hA00002;
  localparam logic [23:0] H_C2 = 24'h5A5A5A;
  localparam logic [23:0] H_D = 24'h2000C2;
  localparam logic [23:0] H_E = 24'h180001;
  localparam logic [23:0] H_F = 24'h100001;
  localparam logic [23:0] H_J = 24'h400003;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic jump_taken = 1'b0;
  logic restart = 1'b0;
  logic [PC_W-1:0] jump_target = '0;
  logic [PC_W-1:0] store_addr;
  logic [WORD_W-1:0] store_data, issue_word, hold_word, w;
  logic [HALF_W-1:0] stage_half;
  logic stage_valid, dec_full, dec_halt, issue_valid, hold_valid, fetch_halted, quiet;
  logic [N_UNITS-1:0] dec_use, issue_unit;
  logic [N_UNITS-1:0][TIME_W-1:0] dec_start, dec_end, unit_busy;
  logic [TIME_W-1:0] dec_hold_time;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int c0, c1;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  iis_far_side far (.sys_clk(sys_clk), .store_addr(store_addr), .store_data(store_data),
    .stage_half(stage_half), .dec_full(dec_full), .dec_use(dec_use), .dec_start(dec_start),
    .dec_end(dec_end), .dec_hold_time(dec_hold_time), .dec_halt(dec_halt));
  iis_issue_scoreboard uut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .store_addr(store_addr),
    .store_data(store_data), .stage_half(stage_half), .stage_valid(stage_valid),
    .dec_full(dec_full), .dec_use(dec_use), .dec_start(dec_start), .dec_end(dec_end),
    .dec_hold_time(dec_hold_time), .dec_halt(dec_halt), .jump_taken(jump_taken),
    .jump_target(jump_target), .restart(restart), .issue_valid(issue_valid),
    .issue_unit(issue_unit), .issue_word(issue_word), .hold_valid(hold_valid),
    .hold_word(hold_word), .unit_busy(unit_busy), .fetch_halted(fetch_halted));
  task automatic wrap_up();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_issue(output int c);
    int i;
    i = 0;
    do begin
      @(posedge sys_clk) #1;
      i++;
    end while (issue_valid !== 1'b1 && i < 300);
    if (issue_valid !== 1'b1) begin
      chk("issue_timeout", 48'h1, 48'h0);
      wrap_up();
    end else begin
      c = cyc;
    end
  endtask
  task automatic t_reset();
    chk("addr", '0, store_addr);
    chk("idle", '0, {stage_valid, issue_valid, hold_valid, fetch_halted, unit_busy});
  endtask
  task automatic t_first_and_conflict();
    wait_issue(c1);
    chk("first_gap", 1, c1 - c0 >= 5);
    chk("word_a", {H_A, 24'h0}, issue_word);
    chk("unit_a", 3'b001, issue_unit);
    chk("busy_int", 6'h04, unit_busy[0]);
    c0 = c1;
    wait_issue(c1);
    // end 4 against start 2: unit free for it two clocks after the first issue, issued one clock later
    chk("conflict_gap", 3, c1 - c0);
  endtask
  task automatic t_full_and_hold();
    wait_issue(c1);
    chk("word_c", {H_C1, H_C2}, issue_word);
    chk("unit_c", 3'b010, issue_unit);
    wait_issue(c1);
    chk("hold_v", 1, hold_valid);
    chk("hold_w", {H_D, 24'h0}, hold_word);
  endtask
  task automatic t_halt();
    wait_issue(c1);
    quiet = 1'b1;
    repeat (12) begin
      @(posedge sys_clk) #1;
      if (issue_valid !== 1'b0) quiet = 1'b0;
    end
    chk("halted", 1, fetch_halted);
    chk("no_issue", 1, quiet);
    @(posedge sys_clk) restart <= 1'b1;
    @(posedge sys_clk) restart <= 1'b0;
    wait_issue(c1);
    chk("word_f", {H_F, 24'h0}, issue_word);
  endtask
  task automatic t_jump();
    @(posedge sys_clk) begin
      jump_taken <= 1'b1;
      jump_target <= 16'h0004;
    end
    @(posedge sys_clk) jump_taken <= 1'b0;
    #1 c0 = cyc;
    chk("jump_addr", 16'h0004, store_addr);
    wait_issue(c1);
    chk("jump_gap", 1, c1 - c0 >= 4);
    chk("word_j", {H_J, 24'h0}, issue_word);
    chk("unit_j", 3'b100, issue_unit);
  endtask
  task automatic t_freeze();
    @(posedge sys_clk) ce <= 1'b0;
    #1 w = {unit_busy, store_addr};
    repeat (4) @(posedge sys_clk);
    #1 chk("frozen", w, {unit_busy, store_addr});
    @(posedge sys_clk) ce <= 1'b1;
  endtask
  initial begin
    for (int i = 0; i < 16; i++) far.mem[i] = '0;
    far.mem[0] = {H_A, H_B};
    far.mem[1] = {H_C1, H_C2};
    far.mem[2] = {H_D, H_E};
    far.mem[3] = {H_F, H_F};
    far.mem[4] = {H_J, H_J};
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    #1 c0 = cyc;
    t_reset();
    t_first_and_conflict();
    t_full_and_hold();
    t_halt();
    t_jump();
    t_freeze();
    wrap_up();
  end
endmodule
`default_nettype wire
